/* File: core/nfcs_defs.svh */
// Register offsets, command codes, status bits and timing counts of the NOR flash sequencer
`ifndef NFCS_DEFS_SVH
`define NFCS_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define NFCS_OFF_CTRL 8'h00
`define NFCS_OFF_ADDR 8'h04
`define NFCS_OFF_WDATA 8'h08
`define NFCS_OFF_STAT 8'h0C
`define NFCS_OFF_RDATA 8'h10

// ****************************************
// Status register fields (host view)
// ****************************************
`define NFCS_STAT_BUSY 8
`define NFCS_STAT_SUSP 9
`define NFCS_STAT_REFUSED 10

// ****************************************
// Flash command codes
// ****************************************
`define NFCS_CMD_PROG_SETUP 8'h40
`define NFCS_CMD_ERASE_SETUP 8'h20
`define NFCS_CMD_CONFIRM 8'hD0
`define NFCS_CMD_LOCK_SETUP 8'h60
`define NFCS_CMD_LOCK_SET 8'h01
`define NFCS_CMD_SUSPEND 8'hB0
`define NFCS_CMD_READ_ARRAY 8'hFF
`define NFCS_CMD_CLEAR_STATUS 8'h50

// ****************************************
// Flash status bits
// ****************************************
`define NFCS_SR_READY 7
`define NFCS_SR_SUSPEND 6
`define NFCS_SR_ERR_MASK 8'h3A

// ****************************************
// Timing
// ****************************************
`define NFCS_CLK_NS 25
`define NFCS_T_WP_NS 70
`define NFCS_T_WPH_NS 30
`define NFCS_T_ACC_NS 150
`define NFCS_T_OEH_NS 25
`define NFCS_SYNC_CYC 2
`define NFCS_WP_CYC ((`NFCS_T_WP_NS + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS)
`define NFCS_WPH_CYC ((`NFCS_T_WPH_NS + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS)
`define NFCS_RD_CYC ((`NFCS_T_ACC_NS + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS + `NFCS_SYNC_CYC)
`define NFCS_OEH_CYC ((`NFCS_T_OEH_NS + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS)

`endif

/* File: core/nfcs_pkg.sv */
// Types of the NOR flash command sequencer
package nfcs_pkg;

    typedef enum logic [3:0] {
        NFCS_OP_NONE = 4'h0,
        NFCS_OP_PROGRAM = 4'h1,
        NFCS_OP_ERASE = 4'h2,
        NFCS_OP_LOCK_SET = 4'h3,
        NFCS_OP_LOCK_CLEAR = 4'h4,
        NFCS_OP_SUSPEND = 4'h5,
        NFCS_OP_RESUME = 4'h6,
        NFCS_OP_CLEAR_STATUS = 4'h7,
        NFCS_OP_READ_ARRAY = 4'h8,
        NFCS_OP_READ_STATUS = 4'h9
    } nfcs_op_t;

    typedef enum logic [5:0] {
        NFCS_ST_IDLE = 6'h01,
        NFCS_ST_WR_SET = 6'h02,
        NFCS_ST_WR_PULSE = 6'h04,
        NFCS_ST_WR_GAP = 6'h08,
        NFCS_ST_RD_WAIT = 6'h10,
        NFCS_ST_RD_GAP = 6'h20
    } nfcs_fsm_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } nfcs_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } nfcs_axi_rsp_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
        logic we_n;
        logic oe_n;
        logic ce_n;
    } nfcs_flash_out_t;

    typedef struct packed {
        nfcs_fsm_t fsm;
        logic [3:0] cnt;
        nfcs_op_t op;
        logic step;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [7:0] sr;
        logic [15:0] rdata;
        logic susp;
        logic refused;
        logic [15:0] sync1;
        logic [15:0] sync2;
        nfcs_axi_rsp_t rsp;
        nfcs_flash_out_t pins;
    } nfcs_state_t;

endpackage

/* File: core/nfcs_host.sv */
// Host-side command sequencer for a parallel NOR flash, run from AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "nfcs_defs.svh"

// Operation
// - Program writes setup code then data, both to the target location.
// - After the last operation host writes read-array; device returns array data.
// - Host clears status before any retry once an error flag is seen.
// - Suspend code to any address; after ready, suspend flag tells suspended or done.
// - During program suspend, read-array and other reads allowed; resume code restarts.
// - Erase setup then confirm to the block, confirm as the very next write.
// - Erase suspend and resume follow the same suspend flag handshake.
// - Lock set is setup code then set-confirm code to the block.
// - Clear all locks is setup then clear-confirm, then read-array to resume.
module nfcs_host
    import nfcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire nfcs_axi_req_t axi_req,
    output nfcs_axi_rsp_t axi_rsp,
    input wire logic [15:0] flash_dq_i,
    output nfcs_flash_out_t flash_out
);

    nfcs_state_t st_reg;
    nfcs_state_t st_next;
    logic wr_fire;
    logic rd_fire;
    logic start_req;
    logic start_ok;
    nfcs_op_t req_op;
    logic [31:0] addr_merged;
    logic [31:0] wdata_merged;

    // ****************************************
    // Command words
    // ****************************************
    function automatic logic two_words(input nfcs_op_t op);
        return (op == NFCS_OP_PROGRAM) || (op == NFCS_OP_ERASE) || (op == NFCS_OP_LOCK_SET) ||
            (op == NFCS_OP_LOCK_CLEAR);
    endfunction

    function automatic logic [15:0] word_of(input nfcs_op_t op, input logic step, input logic [15:0] data);
        logic [7:0] c;
        c = `NFCS_CMD_READ_ARRAY;
        case (op)
            NFCS_OP_PROGRAM: c = `NFCS_CMD_PROG_SETUP;
            NFCS_OP_ERASE: c = step ? `NFCS_CMD_CONFIRM : `NFCS_CMD_ERASE_SETUP;
            NFCS_OP_LOCK_SET: c = step ? `NFCS_CMD_LOCK_SET : `NFCS_CMD_LOCK_SETUP;
            NFCS_OP_LOCK_CLEAR: c = step ? `NFCS_CMD_CONFIRM : `NFCS_CMD_LOCK_SETUP;
            NFCS_OP_SUSPEND: c = `NFCS_CMD_SUSPEND;
            NFCS_OP_RESUME: c = `NFCS_CMD_CONFIRM;
            NFCS_OP_CLEAR_STATUS: c = `NFCS_CMD_CLEAR_STATUS;
            default: c = `NFCS_CMD_READ_ARRAY;
        endcase
        if (op == NFCS_OP_PROGRAM && step) begin
            return data;
        end
        return {8'h00, c};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // Request check
    // ****************************************
    // Recovery order: with an error latched only clear-status and reads go through.
    assign wr_fire = st_reg.rsp.awready && axi_req.awvalid && axi_req.wvalid;
    assign rd_fire = st_reg.rsp.arready && axi_req.arvalid;
    assign req_op = nfcs_op_t'(axi_req.wdata[3:0]);
    // A function result cannot be part-selected, so the merged words are named first
    assign addr_merged = merge({8'h00, st_reg.addr}, axi_req.wdata, axi_req.wstrb);
    assign wdata_merged = merge({16'h0000, st_reg.wdata}, axi_req.wdata, axi_req.wstrb);
    assign start_req = wr_fire && (axi_req.awaddr == `NFCS_OFF_CTRL) && axi_req.wstrb[0];
    assign start_ok = (st_reg.fsm == NFCS_ST_IDLE) && (req_op != NFCS_OP_NONE) && (req_op <= NFCS_OP_READ_STATUS) &&
        !((st_reg.sr & `NFCS_SR_ERR_MASK) != 8'h00 && req_op != NFCS_OP_CLEAR_STATUS &&
          req_op != NFCS_OP_READ_ARRAY && req_op != NFCS_OP_READ_STATUS) &&
        !(st_reg.susp && req_op == NFCS_OP_ERASE);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = flash_dq_i;
        st_next.sync2 = st_reg.sync1;
        // Slave waits for both address and data, then takes them in one edge
        if (wr_fire) begin
            st_next.rsp.awready = 1'b0;
            st_next.rsp.wready = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            if (axi_req.awaddr == `NFCS_OFF_ADDR) begin
                st_next.addr = addr_merged[23:0];
            end
            if (axi_req.awaddr == `NFCS_OFF_WDATA) begin
                st_next.wdata = wdata_merged[15:0];
            end
        end else if (!st_reg.rsp.bvalid && !st_reg.rsp.awready && axi_req.awvalid && axi_req.wvalid) begin
            st_next.rsp.awready = 1'b1;
            st_next.rsp.wready = 1'b1;
        end
        if (st_reg.rsp.bvalid && axi_req.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        if (rd_fire) begin
            st_next.rsp.arready = 1'b0;
            st_next.rsp.rvalid = 1'b1;
            case (axi_req.araddr)
                `NFCS_OFF_CTRL: st_next.rsp.rdata = {28'h0000000, st_reg.op};
                `NFCS_OFF_ADDR: st_next.rsp.rdata = {8'h00, st_reg.addr};
                `NFCS_OFF_WDATA: st_next.rsp.rdata = {16'h0000, st_reg.wdata};
                `NFCS_OFF_STAT: st_next.rsp.rdata = {21'h000000, st_reg.refused, st_reg.susp,
                    st_reg.fsm != NFCS_ST_IDLE, st_reg.sr};
                `NFCS_OFF_RDATA: st_next.rsp.rdata = {16'h0000, st_reg.rdata};
                default: st_next.rsp.rdata = 32'h00000000;
            endcase
        end else if (!st_reg.rsp.rvalid && !st_reg.rsp.arready && axi_req.arvalid) begin
            st_next.rsp.arready = 1'b1;
        end
        if (st_reg.rsp.rvalid && axi_req.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end
        if (start_req) begin
            st_next.refused = !start_ok;
        end
        case (st_reg.fsm)
            NFCS_ST_IDLE: begin
                if (start_req && start_ok) begin
                    st_next.op = req_op;
                    st_next.step = 1'b0;
                    st_next.pins.ce_n = 1'b0;
                    st_next.pins.addr = st_reg.addr;
                    if (req_op == NFCS_OP_RESUME) begin
                        st_next.susp = 1'b0;
                    end
                    if (req_op == NFCS_OP_CLEAR_STATUS) begin
                        st_next.sr = st_reg.sr & ~`NFCS_SR_ERR_MASK;
                    end
                    if (req_op == NFCS_OP_READ_STATUS) begin
                        st_next.pins.oe_n = 1'b0;
                        st_next.cnt = 4'(`NFCS_RD_CYC - 1);
                        st_next.fsm = NFCS_ST_RD_WAIT;
                    end else begin
                        st_next.pins.dq_oe = 1'b1;
                        st_next.pins.dq_o = word_of(req_op, 1'b0, st_reg.wdata);
                        st_next.fsm = NFCS_ST_WR_SET;
                    end
                end
            end
            NFCS_ST_WR_SET: begin
                st_next.pins.we_n = 1'b0;
                st_next.cnt = 4'(`NFCS_WP_CYC - 1);
                st_next.fsm = NFCS_ST_WR_PULSE;
            end
            NFCS_ST_WR_PULSE: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h0) begin
                    st_next.pins.we_n = 1'b1;
                    st_next.cnt = 4'(`NFCS_WPH_CYC - 1);
                    st_next.fsm = NFCS_ST_WR_GAP;
                end
            end
            NFCS_ST_WR_GAP: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h0) begin
                    if (!st_reg.step && two_words(st_reg.op)) begin
                        // Second word leaves at once, to the same address
                        st_next.step = 1'b1;
                        st_next.pins.dq_o = word_of(st_reg.op, 1'b1, st_reg.wdata);
                        st_next.fsm = NFCS_ST_WR_SET;
                    end else begin
                        st_next.pins.dq_oe = 1'b0;
                        if (st_reg.op == NFCS_OP_CLEAR_STATUS) begin
                            st_next.pins.ce_n = 1'b1;
                            st_next.fsm = NFCS_ST_IDLE;
                        end else begin
                            // Bus released and output enabled in one edge; host waits NFCS_RD_CYC cycles for the data
                            st_next.pins.oe_n = 1'b0;
                            st_next.cnt = 4'(`NFCS_RD_CYC - 1);
                            st_next.fsm = NFCS_ST_RD_WAIT;
                        end
                    end
                end
            end
            NFCS_ST_RD_WAIT: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h0) begin
                    if (st_reg.op == NFCS_OP_READ_ARRAY) begin
                        st_next.rdata = st_reg.sync2;
                        st_next.pins.oe_n = 1'b1;
                        st_next.pins.ce_n = 1'b1;
                        st_next.fsm = NFCS_ST_IDLE;
                    end else begin
                        st_next.sr = st_reg.sync2[7:0];
                        if (st_reg.sync2[`NFCS_SR_READY]) begin
                            if (st_reg.op == NFCS_OP_SUSPEND) begin
                                st_next.susp = st_reg.sync2[`NFCS_SR_SUSPEND];
                            end
                            st_next.pins.oe_n = 1'b1;
                            st_next.pins.ce_n = 1'b1;
                            st_next.fsm = NFCS_ST_IDLE;
                        end else begin
                            st_next.pins.oe_n = 1'b1;
                            st_next.cnt = 4'(`NFCS_OEH_CYC - 1);
                            st_next.fsm = NFCS_ST_RD_GAP;
                        end
                    end
                end
            end
            NFCS_ST_RD_GAP: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h0) begin
                    st_next.pins.oe_n = 1'b0;
                    st_next.cnt = 4'(`NFCS_RD_CYC - 1);
                    st_next.fsm = NFCS_ST_RD_WAIT;
                end
            end
            default: begin
                st_next.pins.ce_n = 1'b1;
                st_next.fsm = NFCS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.fsm <= NFCS_ST_IDLE;
            st_reg.pins.we_n <= 1'b1;
            st_reg.pins.oe_n <= 1'b1;
            st_reg.pins.ce_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign axi_rsp = st_reg.rsp;
    assign flash_out = st_reg.pins;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_erase_setup;
        $rose(st_reg.pins.we_n) && st_reg.op == NFCS_OP_ERASE && !st_reg.step;
    endsequence
    sequence s_erase_confirm;
        !st_reg.pins.we_n && st_reg.pins.dq_o[7:0] == `NFCS_CMD_CONFIRM && $stable(st_reg.pins.addr);
    endsequence

    a_prog_words: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_PROGRAM) |->
        st_reg.pins.dq_o == (st_reg.step ? st_reg.wdata : {8'h00, `NFCS_CMD_PROG_SETUP}))
        else $error("program word wrong");
    a_erase_pair: assert property (s_erase_setup |-> st_reg.pins.we_n [*3] ##1 s_erase_confirm)
        else $error("erase confirm not next write");
    a_read_array: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_READ_ARRAY) |->
        st_reg.pins.dq_o[7:0] == `NFCS_CMD_READ_ARRAY)
        else $error("read-array code wrong");
    a_suspend_code: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_SUSPEND) |->
        st_reg.pins.dq_o[7:0] == `NFCS_CMD_SUSPEND)
        else $error("suspend code wrong");
    a_suspend_flag: assert property ((st_reg.fsm == NFCS_ST_RD_WAIT && st_reg.cnt == 4'h0 &&
        st_reg.op == NFCS_OP_SUSPEND && st_reg.sync2[`NFCS_SR_READY]) |=>
        st_reg.susp == $past(st_reg.sync2[`NFCS_SR_SUSPEND]) && st_reg.fsm == NFCS_ST_IDLE)
        else $error("suspend flag not captured");
    a_resume_code: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_RESUME) |->
        st_reg.pins.dq_o[7:0] == `NFCS_CMD_CONFIRM && !st_reg.susp)
        else $error("resume code wrong");
    a_lock_set: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_LOCK_SET) |->
        st_reg.pins.dq_o[7:0] == (st_reg.step ? `NFCS_CMD_LOCK_SET : `NFCS_CMD_LOCK_SETUP))
        else $error("lock set sequence wrong");
    a_lock_clear: assert property (($fell(st_reg.pins.we_n) && st_reg.op == NFCS_OP_LOCK_CLEAR) |->
        st_reg.pins.dq_o[7:0] == (st_reg.step ? `NFCS_CMD_CONFIRM : `NFCS_CMD_LOCK_SETUP))
        else $error("lock clear sequence wrong");
    a_err_refuse: assert property ((start_req && st_reg.fsm == NFCS_ST_IDLE &&
        (st_reg.sr & `NFCS_SR_ERR_MASK) != 8'h00 && req_op == NFCS_OP_PROGRAM) |=>
        st_reg.refused && st_reg.fsm == NFCS_ST_IDLE [*2])
        else $error("operation started over latched error");
    a_poll_toggle: assert property ((st_reg.fsm == NFCS_ST_RD_WAIT && st_reg.cnt == 4'h0 &&
        st_reg.op != NFCS_OP_READ_ARRAY && !st_reg.sync2[`NFCS_SR_READY]) |=>
        st_reg.pins.oe_n ##1 !st_reg.pins.oe_n && st_reg.fsm == NFCS_ST_RD_WAIT)
        else $error("busy poll did not toggle output enable");

endmodule

/* File: tb/nfcs_flash_model.sv */
// Behavioural NOR flash device facing the sequencer's pins
`timescale 1ns/10ps
module nfcs_flash_model
    import nfcs_pkg::*;
#(
    parameter int BUSY_PROG = 40,
    parameter int BUSY_ERASE = 120
)
(
    input wire logic sys_clk,
    input wire nfcs_flash_out_t pins,
    input wire logic vpen_ok,
    input wire logic fail_op,
    output logic [15:0] dq_dev
);
    logic [15:0] mem [int];
    logic [39:0] wlog [$];
    bit [255:0] locked = '0;
    bit [7:0] pend = 8'h00;
    bit stat_mode = 1'b0;
    bit susp = 1'b0;
    bit e5 = 1'b0;
    bit e4 = 1'b0;
    bit e3 = 1'b0;
    bit e1 = 1'b0;
    int busy = 0;
    logic prev_we = 1'b1;
    logic prev_oe = 1'b1;
    logic [7:0] sr_lat = 8'h80;
    logic [15:0] arr_q = 16'hFFFF;
    logic [15:0] last = 16'h0000;

    // ****************************************
    // Command decoding
    // ****************************************
    function automatic logic [7:0] sr_now();
        return {busy == 0 || susp, susp, e5, e4, e3, 1'b0, e1, 1'b0};
    endfunction

    task automatic handle(input logic [23:0] ad, input logic [15:0] wd);
        int ks [$];
        wlog.push_back({ad, wd});
        stat_mode = (wd[7:0] != 8'hFF) || (pend != 8'h00);
        if (pend == 8'h40) begin
            if (!vpen_ok) e3 = 1'b1;
            else if (locked[ad[23:16]]) e1 = 1'b1;
            else if (fail_op) e4 = 1'b1;
            else begin
                mem[ad] = wd;
                busy = BUSY_PROG;
            end
        end else if (pend == 8'h20) begin
            if (wd[7:0] != 8'hD0) {e5, e4} = 2'b11;
            else begin
                foreach (mem[k]) if (k[23:16] == ad[23:16]) ks.push_back(k);
                foreach (ks[i]) mem.delete(ks[i]);
                busy = BUSY_ERASE;
            end
        end else if (pend == 8'h60) begin
            if (!vpen_ok) e3 = 1'b1;
            else if (wd[7:0] == 8'h01 && fail_op) e4 = 1'b1;
            else if (wd[7:0] == 8'h01) locked[ad[23:16]] = 1'b1;
            else if (wd[7:0] == 8'hD0 && fail_op) e5 = 1'b1;
            else if (wd[7:0] == 8'hD0) locked = '0;
            else {e5, e4} = 2'b11;
        end else begin
            case (wd[7:0])
                8'hB0: susp = busy > 0;
                8'hD0: susp = 1'b0;
                8'h50: {e5, e4, e3, e1} = 4'h0;
                default: ;
            endcase
        end
        pend = (pend == 8'h00 && wd[7:0] inside {8'h40, 8'h20, 8'h60}) ? wd[7:0] : 8'h00;
    endtask

    // ****************************************
    // Pin behaviour
    // ****************************************
    always @(posedge sys_clk) begin
        if (busy > 0 && !susp) busy--;
        if (!prev_we && pins.we_n && !pins.ce_n) handle(pins.addr, pins.dq_o);
        // A held-low output enable shows a stale status until it is toggled
        if (prev_oe && !pins.oe_n) sr_lat = sr_now();
        arr_q = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hFFFF;
        if (!pins.ce_n && !pins.oe_n) last = dq_dev;
        prev_we = pins.we_n;
        prev_oe = pins.oe_n;
    end

    // Released bus shows the inverse of the last value, never a friendly constant
    always @* begin
        if (!pins.ce_n && !pins.oe_n) dq_dev = stat_mode ? {8'h00, sr_lat} : arr_q;
        else dq_dev = ~last;
    end
endmodule

/* File: tb/nfcs_host_tb.sv */
// Self-checking bench of the NOR flash sequencer driven over AXI4-Lite
`timescale 1ns/10ps
`include "nfcs_defs.svh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module nfcs_host_tb
    import nfcs_pkg::*;
;
    typedef struct packed {logic chk; logic [31:0] e; logic [31:0] m;} nfcs_exp_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    nfcs_axi_req_t req = '0;
    nfcs_axi_rsp_t rsp;
    nfcs_flash_out_t fo;
    logic [15:0] dq_dev;
    logic [15:0] dq_i;
    logic vpen_ok = 1'b1;
    logic fail_op = 1'b0;
    int failures = 0;
    int n_compared = 0;
    int n;
    nfcs_exp_t exp_q [$];
    logic [31:0] seed = 32'h00014909;
    logic [31:0] rv;
    logic [31:0] a;
    logic [31:0] d;

    always #12.5 sys_clk = ~sys_clk;
    assign dq_i = fo.dq_oe ? fo.dq_o : dq_dev;

    nfcs_host u_nfcs_host(.sys_clk(sys_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .flash_dq_i(dq_i),
        .flash_out(fo));
    nfcs_flash_model u_nfcs_flash_model(.sys_clk(sys_clk), .pins(fo), .vpen_ok(vpen_ok), .fail_op(fail_op),
        .dq_dev(dq_dev));

    // ****************************************
    // Bus tasks
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic axw(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge sys_clk);
        req.awvalid <= 1'b1;
        req.awaddr <= ad;
        req.wvalid <= 1'b1;
        req.wdata <= wd;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        do @(posedge sys_clk); while (rsp.awready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic c, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back('{c, e, m});
        @(posedge sys_clk);
        req.arvalid <= 1'b1;
        req.araddr <= ad;
        req.rready <= 1'b1;
        do @(posedge sys_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
        rv = rsp.rdata;
        req.rready <= 1'b0;
    endtask

    task automatic poll();
        do rd(`NFCS_OFF_STAT, 1'b0, 32'h0, 32'h0); while (rv[`NFCS_STAT_BUSY] !== 1'b0);
    endtask

    task automatic op(input logic [3:0] code, input logic [31:0] ad);
        axw(`NFCS_OFF_ADDR, ad);
        axw(`NFCS_OFF_WDATA, d);
        axw(`NFCS_OFF_CTRL, {28'h0000000, code});
        poll();
    endtask

    task automatic st(input logic [31:0] e, input logic [31:0] m);
        rd(`NFCS_OFF_STAT, 1'b1, e, m);
    endtask

    task automatic wl(input int back, input logic [39:0] e);
        `CMP(u_nfcs_flash_model.wlog[u_nfcs_flash_model.wlog.size() - 1 - back], e)
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Checking and sequence
    // ****************************************
    always @(posedge sys_clk) begin
        if (rsp.rvalid === 1'b1 && req.rready && exp_q.size() > 0) begin
            nfcs_exp_t x;
            x = exp_q.pop_front();
            if (x.chk) `CMP(rsp.rdata & x.m, x.e & x.m)
        end
    end

    initial begin
        #1000000;
        failures++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h14, 1'b1, 32'h0, 32'hFFFFFFFF);
        a = (xs() & 32'h0000FFFF) | 32'h00010000;
        d = xs() & 32'h0000FFFF;
        op(4'h1, a);
        wl(1, {a[23:0], 16'h0040});
        wl(0, {a[23:0], d[15:0]});
        st(32'h080, 32'h3FF);
        op(4'h8, a);
        wl(0, {a[23:0], 16'h00FF});
        rd(`NFCS_OFF_RDATA, 1'b1, d, 32'hFFFF);
        // Errors are sticky: the next program is turned away until cleared
        fail_op <= 1'b1;
        op(4'h1, a ^ 32'h1);
        fail_op <= 1'b0;
        st(32'h090, 32'hFF);
        n = u_nfcs_flash_model.wlog.size();
        op(4'h1, a);
        st(32'h490, 32'h4FF);
        `CMP(u_nfcs_flash_model.wlog.size(), n)
        op(4'h7, a);
        st(32'h080, 32'hFF);
        vpen_ok <= 1'b0;
        op(4'h1, a);
        vpen_ok <= 1'b1;
        st(32'h088, 32'hFF);
        op(4'h7, a);
        op(4'h3, a);
        wl(1, {a[23:0], 16'h0060});
        wl(0, {a[23:0], 16'h0001});
        op(4'h1, a);
        st(32'h082, 32'hFF);
        op(4'h7, a);
        op(4'h4, a);
        wl(0, {a[23:0], 16'h00D0});
        st(32'h080, 32'hFF);
        op(4'h1, a);
        st(32'h080, 32'hFF);
        fail_op <= 1'b1;
        op(4'h3, a);
        st(32'h090, 32'hFF);
        op(4'h7, a);
        op(4'h4, a);
        st(32'h0A0, 32'hFF);
        fail_op <= 1'b0;
        op(4'h7, a);
        op(4'h2, a);
        wl(1, {a[23:0], 16'h0020});
        wl(0, {a[23:0], 16'h00D0});
        op(4'h8, a);
        rd(`NFCS_OFF_RDATA, 1'b1, 32'hFFFF, 32'hFFFF);
        // A second erase order while the first runs must not reach the flash
        n = u_nfcs_flash_model.wlog.size();
        axw(`NFCS_OFF_ADDR, a);
        axw(`NFCS_OFF_CTRL, 32'h2);
        axw(`NFCS_OFF_CTRL, 32'h2);
        poll();
        st(32'h480, 32'h4FF);
        `CMP(u_nfcs_flash_model.wlog.size(), n + 2)
        op(4'h5, a);
        wl(0, {a[23:0], 16'h00B0});
        st(32'h080, 32'h2FF);
        op(4'h6, a);
        wl(0, {a[23:0], 16'h00D0});
        st(32'h080, 32'h2FF);
        close_out();
    end
endmodule
